/* File: core/hcs_defines.svh */
// register map, field positions and reset values of the host status block
`ifndef HCS_DEFINES_SVH
`define HCS_DEFINES_SVH

`define HCS_OFF_CMD 8'h00
`define HCS_OFF_STS 8'h04
`define HCS_OFF_INTEN 8'h08

`define HCS_STS_RESET 32'h00001000
`define HCS_CMD_RESET 32'h00000000
`define HCS_INTEN_RESET 6'h00

`define HCS_STS_ASYNC_ST 15
`define HCS_STS_PERIODIC_ST 14
`define HCS_STS_RECLAIM 13
`define HCS_STS_HALTED 12
`define HCS_STS_ASYNC_ADV 5
`define HCS_STS_HOST_ERR 4
`define HCS_STS_ROLLOVER 3
`define HCS_STS_PORT_CHG 2
`define HCS_STS_XFER_ERR 1
`define HCS_STS_XFER_DONE 0

// flags that software clears by writing one; host error is read-only
`define HCS_W1C_MASK 6'h2F

`define HCS_CMD_RUN 0
`define HCS_CMD_PERIODIC_EN 4
`define HCS_CMD_ASYNC_EN 5
`define HCS_CMD_DOORBELL 6

`endif

/* File: core/hcs_pkg.sv */
// types shared by the host status block
package hcs_pkg;

  // one completed transaction as reported by the schedule engine
  typedef struct packed {
    logic done;
    logic error;
    logic irq_on_completion_request;
    logic short_pkt;
  } hcs_xfer_evt_t;

  // actual state of the schedule engine
  typedef struct packed {
    logic async_running;
    logic periodic_running;
    logic reclaim;
    logic stopped;
  } hcs_engine_st_t;

  // event flag vector, bit order as in the status word
  typedef logic [5:0] hcs_flags_t;

endpackage

/* File: core/hcs_status.sv */
// host controller status word with command and interrupt enable over apb
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "hcs_defines.svh"

module hcs_status
  import hcs_pkg::*;
#(
  parameter int NUM_PORTS = 6
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // schedule engine
  input wire hcs_engine_st_t engine_st,
  input wire logic async_advanced,
  input wire logic bus_read_error,
  input wire hcs_xfer_evt_t xfer_evt,
  input wire logic frame_number_counter_b13,
  // ports, owner one means the companion controller holds the port
  input wire logic [NUM_PORTS-1:0] port_change,
  input wire logic [NUM_PORTS-1:0] port_resume,
  input wire logic [NUM_PORTS-1:0] port_owner,
  // control to the engine and interrupt
  output logic run_ctrl,
  output logic async_sched_en,
  output logic periodic_sched_en,
  output logic doorbell_pending,
  output logic irq
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  logic run_reg;
  logic async_en_reg;
  logic periodic_en_reg;
  logic doorbell_reg;
  logic halted_reg;
  logic async_st_reg;
  logic periodic_st_reg;
  logic reclaim_reg;
  logic frame_b13_reg;
  logic [NUM_PORTS-1:0] port_change_prev_reg;
  logic [NUM_PORTS-1:0] port_resume_prev_reg;
  hcs_flags_t flags_reg;
  hcs_flags_t flags_next;
  hcs_flags_t flags_set;
  hcs_flags_t flags_clr;
  logic [5:0] inten_reg;
  logic irq_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic access;
  logic wr_cmd;
  logic wr_sts;
  logic wr_inten;
  logic mapped;
  logic run_set_sw;
  logic [31:0] sts_word;

  // zero wait state: pready rises in the access phase of every transfer
  assign access = psel & penable & pready_reg;
  assign wr_cmd = access & pwrite & hit(paddr, `HCS_OFF_CMD);
  assign wr_sts = access & pwrite & hit(paddr, `HCS_OFF_STS);
  assign wr_inten = access & pwrite & hit(paddr, `HCS_OFF_INTEN);
  assign mapped = hit(paddr, `HCS_OFF_CMD) | hit(paddr, `HCS_OFF_STS) |
                  hit(paddr, `HCS_OFF_INTEN);
  assign run_set_sw = wr_cmd & pwdata[`HCS_CMD_RUN] & ~bus_read_error;

  // reserved fields are constant zero, so writes there do nothing
  always_comb
  begin
    sts_word = 32'h00000000;
    sts_word[`HCS_STS_ASYNC_ST] = async_st_reg;
    sts_word[`HCS_STS_PERIODIC_ST] = periodic_st_reg;
    sts_word[`HCS_STS_RECLAIM] = reclaim_reg;
    sts_word[`HCS_STS_HALTED] = halted_reg;
    sts_word[5:0] = flags_reg;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      pready_reg <= psel & ~penable & ~pready_reg;
      pslverr_reg <= psel & ~penable & ~pready_reg & ~mapped;
      if (psel & ~penable & ~pwrite)
      begin
        if (hit(paddr, `HCS_OFF_STS))
          prdata_reg <= sts_word;
        else if (hit(paddr, `HCS_OFF_CMD))
          prdata_reg <= {25'h0000000, doorbell_reg, async_en_reg,
                         periodic_en_reg, 3'h0, run_reg};
        else if (hit(paddr, `HCS_OFF_INTEN))
          prdata_reg <= {26'h0000000, inten_reg};
        else
          prdata_reg <= 32'h00000000;
      end
    end
  end

  // command word: a host system error overrides a software run request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_reg <= 1'((`HCS_CMD_RESET >> `HCS_CMD_RUN) & 32'h1);
      async_en_reg <= 1'b0;
      periodic_en_reg <= 1'b0;
    end
    else
    begin
      if (bus_read_error)
        run_reg <= 1'b0;
      else if (wr_cmd)
        run_reg <= pwdata[`HCS_CMD_RUN];
      if (wr_cmd)
      begin
        async_en_reg <= pwdata[`HCS_CMD_ASYNC_EN];
        periodic_en_reg <= pwdata[`HCS_CMD_PERIODIC_EN];
      end
    end
  end

  // doorbell waits for the engine's next async advance
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      doorbell_reg <= 1'b0;
    else if (wr_cmd & pwdata[`HCS_CMD_DOORBELL])
      doorbell_reg <= 1'b1;
    else if (async_advanced)
      doorbell_reg <= 1'b0;
  end

  // halted waits for the engine to report it really stopped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      halted_reg <= 1'((`HCS_STS_RESET >> `HCS_STS_HALTED) & 32'h1);
    else if (run_set_sw)
      halted_reg <= 1'b0;
    else if (run_reg & ~bus_read_error)
      halted_reg <= 1'b0;
    else if (engine_st.stopped)
      halted_reg <= 1'b1;
  end

  // engine state is mirrored, so it lags the enables by design
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      async_st_reg <= 1'b0;
      periodic_st_reg <= 1'b0;
      reclaim_reg <= 1'b0; // whole-word reset wins over field default
    end
    else
    begin
      async_st_reg <= engine_st.async_running;
      periodic_st_reg <= engine_st.periodic_running;
      reclaim_reg <= engine_st.reclaim;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame_b13_reg <= 1'b0;
      port_change_prev_reg <= '0;
      port_resume_prev_reg <= '0;
    end
    else
    begin
      frame_b13_reg <= frame_number_counter_b13;
      port_change_prev_reg <= port_change;
      port_resume_prev_reg <= port_resume;
    end
  end

  // controller-level events reach the word, and so do the per-transaction
  // error results of xfer_evt and the completions that request an interrupt or end short
  always_comb
  begin
    flags_set = 6'h00;
    flags_set[`HCS_STS_ASYNC_ADV] = doorbell_reg & async_advanced;
    flags_set[`HCS_STS_HOST_ERR] = bus_read_error;
    flags_set[`HCS_STS_ROLLOVER] =
      frame_b13_reg ^ frame_number_counter_b13;
    flags_set[`HCS_STS_PORT_CHG] =
      |(~port_owner & ((port_change & ~port_change_prev_reg) |
                       (port_resume & ~port_resume_prev_reg)));
    flags_set[`HCS_STS_XFER_ERR] = xfer_evt.done & xfer_evt.error;
    flags_set[`HCS_STS_XFER_DONE] =
      xfer_evt.done & (xfer_evt.irq_on_completion_request |
                       xfer_evt.short_pkt);
    flags_clr = wr_sts ? (pwdata[5:0] & `HCS_W1C_MASK) : 6'h00;
    flags_next = (flags_reg & ~flags_clr) | flags_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_reg <= 6'(`HCS_STS_RESET & 32'h3F);
    else
      flags_reg <= flags_next;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      inten_reg <= `HCS_INTEN_RESET;
    else if (wr_inten)
      inten_reg <= pwdata[5:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(flags_next & (wr_inten ? pwdata[5:0] : inten_reg));
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign run_ctrl = run_reg;
  assign async_sched_en = async_en_reg;
  assign periodic_sched_en = periodic_en_reg;
  assign doorbell_pending = doorbell_reg;
  assign irq = irq_reg;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_halt_run_excl: assert property (run_reg |-> !halted_reg)
    else $error("halted set while running");
  a_run_clears_halt: assert property (run_set_sw |=> !halted_reg)
    else $error("halted not cleared on run");
  a_halt_after_stop: assert property
    (!run_reg && engine_st.stopped && !run_set_sw |=> halted_reg)
    else $error("halted not set after stop");
  a_halt_needs_stop: assert property
    (!halted_reg && !engine_st.stopped |=> !halted_reg)
    else $error("halted without stop");
  a_hse_stops_run: assert property
    (bus_read_error |=> !run_reg && flags_reg[`HCS_STS_HOST_ERR])
    else $error("host error did not stop run");
  a_hse_read_only: assert property
    (flags_reg[`HCS_STS_HOST_ERR] |=> flags_reg[`HCS_STS_HOST_ERR])
    else $error("host error flag cleared");
  a_w1c_clear: assert property
    (wr_sts && pwdata[0] && !flags_set[0] |=> !flags_reg[0])
    else $error("write one did not clear");
  a_w0_keep: assert property
    (wr_sts && !pwdata[1] && flags_reg[1] |=> flags_reg[1])
    else $error("write zero changed flag");
  a_set_wins: assert property
    (wr_sts && pwdata[0] && flags_set[0] |=> flags_reg[0])
    else $error("set lost against clear");
  a_rollover_set: assert property
    ($changed(frame_number_counter_b13) |=> flags_reg[3])
    else $error("rollover missed");
  a_both_flags: assert property
    (xfer_evt.done && xfer_evt.error && xfer_evt.irq_on_completion_request
     |=> flags_reg[1] && flags_reg[0])
    else $error("error with completion request not both set");
  a_async_adv: assert property
    (doorbell_reg && async_advanced |=> flags_reg[5] && !doorbell_reg)
    else $error("async advance flag missed");
  a_irq_gate: assert property
    (irq_reg == |(flags_reg & inten_reg))
    else $error("irq does not match flags and enables");
  a_rsvd_zero: assert property
    (psel && !penable && !pwrite && hit(paddr, `HCS_OFF_STS)
     |=> prdata_reg[31:16] == 16'h0000 && prdata_reg[11:6] == 6'h00)
    else $error("reserved status bits nonzero");

  // event flags: each must follow its event one cycle later and never
  // rise without one, since software polls them with interrupts off
  a_port_chg_set: assert property
    (|(~port_owner & ((port_change & ~$past(port_change)) |
                      (port_resume & ~$past(port_resume))))
     |=> flags_reg[`HCS_STS_PORT_CHG])
    else $error("port change missed");
  a_port_chg_only: assert property
    (!flags_reg[`HCS_STS_PORT_CHG] && !(|(~port_owner & (port_change |
     port_resume))) |=> !flags_reg[`HCS_STS_PORT_CHG])
    else $error("port change without owned port event");
  a_xfer_err_set: assert property
    (xfer_evt.done && xfer_evt.error |=> flags_reg[`HCS_STS_XFER_ERR])
    else $error("transfer error flag missed");
  a_xfer_err_only: assert property
    (!flags_reg[`HCS_STS_XFER_ERR] && !xfer_evt.done
     |=> !flags_reg[`HCS_STS_XFER_ERR])
    else $error("transfer error flag without event");
  a_done_on_ioc: assert property
    (xfer_evt.done && xfer_evt.irq_on_completion_request
     |=> flags_reg[`HCS_STS_XFER_DONE])
    else $error("completion flag missed");
  a_done_on_short: assert property
    (xfer_evt.done && xfer_evt.short_pkt |=> flags_reg[`HCS_STS_XFER_DONE])
    else $error("short packet did not set completion flag");
  a_done_needs_evt: assert property
    (!flags_reg[`HCS_STS_XFER_DONE] && !xfer_evt.done
     |=> !flags_reg[`HCS_STS_XFER_DONE])
    else $error("completion flag without event");
  a_rollover_only: assert property
    (!flags_reg[`HCS_STS_ROLLOVER] && $past(presetn) &&
     !$changed(frame_number_counter_b13)
     |=> !flags_reg[`HCS_STS_ROLLOVER])
    else $error("rollover without toggle");
  a_w1c_rollover: assert property
    (wr_sts && pwdata[3] && !flags_set[3] |=> !flags_reg[3])
    else $error("write one did not clear rollover");
  a_w1c_port: assert property
    (wr_sts && pwdata[2] && !flags_set[2] |=> !flags_reg[2])
    else $error("write one did not clear port change");
  a_adv_needs_bell: assert property
    (!flags_reg[`HCS_STS_ASYNC_ADV] && !(doorbell_reg && async_advanced)
     |=> !flags_reg[`HCS_STS_ASYNC_ADV])
    else $error("async advance flag without doorbell");
  a_flag_polled: assert property
    (bus_read_error && inten_reg == 6'h00 && !wr_inten
     |=> flags_reg[`HCS_STS_HOST_ERR] && !irq_reg)
    else $error("masked event not kept for polling");
  a_hse_irq: assert property
    (bus_read_error && inten_reg[`HCS_STS_HOST_ERR] && !wr_inten
     |=> irq_reg)
    else $error("enabled host error gave no interrupt");
  a_state_mirror: assert property
    (1'b1 |=> {async_st_reg, periodic_st_reg, reclaim_reg} ==
     $past(engine_st[3:1]))
    else $error("engine state not mirrored");

  c_hse_irq: cover property (bus_read_error ##1 irq_reg);
  c_clear_race: cover property (wr_sts && pwdata[0] && flags_set[0]);
  c_run_stop: cover property (run_reg ##[1:20] halted_reg);
  c_port_change: cover property (flags_set[`HCS_STS_PORT_CHG]);
  c_short_pkt: cover property (xfer_evt.done && xfer_evt.short_pkt);

endmodule // hcs_status
`default_nettype wire

/* File: core/hcs_status_unused_placeholder_none.sv */
// intentionally empty of logic: status block has a single design file
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* File: tb/hcs_engine_model.sv */
// behavioural schedule engine that answers the command outputs
`timescale 1ns/1ns
`default_nettype none
module hcs_engine_model
  import hcs_pkg::*;
#(
  parameter int LAG = 5
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // commands from the block; reclaim_req comes from the bench
  input wire logic run_ctrl,
  input wire logic async_sched_en,
  input wire logic periodic_sched_en,
  input wire logic doorbell_pending,
  input wire logic reclaim_req,
  // engine state and advance pulse
  output hcs_engine_st_t engine_st,
  output logic async_advanced
);
  logic [LAG-1:0] run_sr, as_sr, ps_sr, db_sr;
  // a real engine finishes its transaction first, so it follows late
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_sr <= '0;
      as_sr <= '0;
      ps_sr <= '0;
      db_sr <= '0;
    end
    else
    begin
      run_sr <= {run_sr[LAG-2:0], run_ctrl};
      as_sr <= {as_sr[LAG-2:0], async_sched_en};
      ps_sr <= {ps_sr[LAG-2:0], periodic_sched_en};
      db_sr <= {db_sr[LAG-2:0], doorbell_pending};
    end
  end
  always_comb
  begin
    engine_st.async_running = as_sr[LAG-1];
    engine_st.periodic_running = ps_sr[LAG-1];
    engine_st.reclaim = reclaim_req;
    engine_st.stopped = ~run_sr[LAG-1];
  end
  // one advance per doorbell, on the rise of the delayed request
  assign async_advanced = db_sr[LAG-2] & ~db_sr[LAG-1];
endmodule // hcs_engine_model
`default_nettype wire

/* File: tb/hcs_status_test.sv */
// self-checking bench of the host status block
`timescale 1ns/1ns
`default_nettype none
module hcs_status_test
  import hcs_pkg::*;
;
  typedef struct packed {
    logic [3:0] xf;
    logic fr;
    logic [5:0] pc;
    logic [5:0] pr;
    logic [5:0] exp;
  } hcs_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic pready, pslverr, run_ctrl, async_sched_en, periodic_sched_en;
  logic doorbell_pending, irq, async_advanced;
  logic bus_read_error = 1'b0, frame_b13 = 1'b0, reclaim_req = 1'b0;
  hcs_engine_st_t engine_st;
  hcs_xfer_evt_t xfer_evt = 4'h0;
  logic [5:0] port_change = 6'h00, port_resume = 6'h00;
  // port 1 belongs to the companion controller
  logic [5:0] port_owner = 6'h02;
  int bad_count = 0, n_tests = 0;
  hcs_row_t rows [9] = '{
    '{4'hC, 1'b0, 6'h00, 6'h00, 6'h02},
    '{4'hE, 1'b0, 6'h00, 6'h00, 6'h03},
    '{4'hA, 1'b0, 6'h00, 6'h00, 6'h01},
    '{4'h9, 1'b0, 6'h00, 6'h00, 6'h01},
    '{4'h8, 1'b0, 6'h00, 6'h00, 6'h00},
    '{4'h0, 1'b1, 6'h00, 6'h00, 6'h08},
    '{4'h0, 1'b0, 6'h01, 6'h00, 6'h04},
    '{4'h0, 1'b0, 6'h02, 6'h00, 6'h00},
    '{4'h0, 1'b0, 6'h00, 6'h08, 6'h04}};

  always #2 pclk = ~pclk;

  hcs_status #(.NUM_PORTS(6)) DUT (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .engine_st,
    .async_advanced, .bus_read_error, .xfer_evt,
    .frame_number_counter_b13(frame_b13), .port_change, .port_resume,
    .port_owner, .run_ctrl, .async_sched_en, .periodic_sched_en,
    .doorbell_pending, .irq);
  hcs_engine_model #(.LAG(5)) engine (.pclk, .presetn, .run_ctrl,
    .async_sched_en, .periodic_sched_en, .doorbell_pending, .reclaim_req,
    .engine_st, .async_advanced);

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer; tog flips the frame bit during the access phase
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, input logic tog = 1'b0);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    if (tog)
      frame_b13 <= ~frame_b13;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  initial
  begin
    #200000;
    bad_count++;
    summarize();
  end

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h04, 32'h00000000);
    chk("reset status", 32'h00001000, rd);
    apb(1'b1, 8'h0C, 32'hFFFFFFFF);
    apb(1'b0, 8'h0C, 32'h00000000);
    chk("unmapped", 32'h00000001, {rd[30:0], err});
    apb(1'b1, 8'h04, 32'hFFFFFFC0);
    apb(1'b0, 8'h04, 32'h00000000);
    chk("reserved", 32'h00001000, rd);
    foreach (rows[i])
    begin
      apb(1'b1, 8'h04, 32'h0000003F);
      xfer_evt <= rows[i].xf;
      frame_b13 <= frame_b13 ^ rows[i].fr;
      port_change <= rows[i].pc;
      port_resume <= rows[i].pr;
      @(posedge pclk);
      xfer_evt <= 4'h0;
      port_change <= 6'h00;
      port_resume <= 6'h00;
      repeat (2) @(posedge pclk);
      apb(1'b0, 8'h04, 32'h00000000);
      chk("row flags", {26'h0, rows[i].exp}, rd & 32'h3F);
      chk("irq masked", 32'h0, {31'h0, irq});
    end
    apb(1'b1, 8'h04, 32'h0000003F);
    reclaim_req <= 1'b1;
    apb(1'b1, 8'h00, 32'h00000031);
    apb(1'b0, 8'h04, 32'h00000000);
    chk("halt clears", 32'h0, rd & 32'h1000);
    repeat (8) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h00000000);
    chk("running", 32'h0000E000, rd);
    apb(1'b1, 8'h00, 32'h00000071);
    chk("cmd outs", 32'h7, {29'h0, doorbell_pending, async_sched_en, periodic_sched_en});
    repeat (12) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h00000000);
    chk("advance", 32'h20, rd & 32'h3F);
    apb(1'b1, 8'h04, 32'h00000020);
    apb(1'b1, 8'h04, 32'h00000008, 1'b1);
    apb(1'b1, 8'h04, 32'h00000000);
    apb(1'b0, 8'h04, 32'h00000000);
    chk("set beats clear", 32'h08, rd & 32'h3F);
    apb(1'b1, 8'h08, 32'h00000008);
    repeat (2) @(posedge pclk);
    chk("irq on", 32'h1, {31'h0, irq});
    apb(1'b1, 8'h04, 32'h00000008);
    repeat (2) @(posedge pclk);
    chk("irq gone", 32'h0, {31'h0, irq});
    apb(1'b1, 8'h00, 32'h00000030);
    apb(1'b0, 8'h04, 32'h00000000);
    chk("still stopping", 32'h0, rd & 32'h1000);
    repeat (10) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h00000000);
    chk("halted", 32'h1000, rd & 32'h1000);
    apb(1'b1, 8'h08, 32'h00000010);
    apb(1'b1, 8'h00, 32'h00000001);
    bus_read_error <= 1'b1;
    @(posedge pclk);
    bus_read_error <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("run dropped", 32'h2, {30'h0, irq, run_ctrl});
    apb(1'b1, 8'h04, 32'h00000010);
    apb(1'b0, 8'h04, 32'h00000000);
    chk("host error", 32'h10, rd & 32'h3F);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    reclaim_req <= 1'b0;
    @(posedge pclk);
    apb(1'b0, 8'h04, 32'h00000000);
    chk("second reset", 32'h00001000, rd);
    summarize();
  end
endmodule // hcs_status_test
`default_nettype wire
